// [rtl/scd_fault_chan.sv]
// One channel's fault flag and protection latch with self-clearing latch-clear bit.
// Assumes fault events are single-cycle or level pulses synchronous to clk_i.
`timescale 1ns/1ns
module scd_fault_chan (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Events and software.
   input  wire logic fault_ev_i,
   input  wire logic clr_wr_i,
   // State.
   output logic      fault_o,
   output logic      latched_o,
   output logic      clr_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latched_o <= 1'b0;
         fault_o   <= 1'b0;
      end else if (fault_ev_i) begin
         latched_o <= 1'b1; // see RL2
         fault_o   <= 1'b1;
      end else if (clr_o) begin
         latched_o <= 1'b0; // see RL2
         fault_o   <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clr_o <= 1'b0;
      end else if (clr_wr_i) begin
         clr_o <= 1'b1;
      end else if (clr_o && !fault_ev_i) begin
         clr_o <= 1'b0; // see RL23
      end
   end

   AST_CLR_RELEASES: assert property (@(posedge clk_i) disable iff (rst_i) // see RL23
      clr_o && !clr_wr_i && !fault_ev_i |=> !clr_o && !latched_o)
      else $error("Latch clear did not release the channel.");
endmodule

// [rtl/scd_pkg.sv]
// Package for the switch channel diagnosis block: register map, field codes, timing counts.
// Assumes a single 10 MHz clock and a classic Wishbone register bus with 32-bit data.
package scd_pkg;
   localparam int unsigned NCH = 8;
   localparam int unsigned CLK_HZ = 10_000_000;

   // Register byte offsets.
   localparam logic [7:0] ADR_FAULT     = 8'h00;
   localparam logic [7:0] ADR_LATCH_CLR = 8'h04;
   localparam logic [7:0] ADR_OSM       = 8'h08;
   localparam logic [7:0] ADR_IOL       = 8'h0C;
   localparam logic [7:0] ADR_SELECTOR  = 8'h10;
   localparam logic [7:0] ADR_ON_OPEN_LOAD_SUMMARY      = 8'h14;
   localparam logic [7:0] ADR_STD_DIAG  = 8'h18;
   localparam logic [7:0] ADR_CFG       = 8'h1C;

   // Standard diagnosis word fields.
   localparam int unsigned STD_OFF_OPEN_LOAD_SUMMARY_BIT = 0;
   localparam int unsigned STD_ON_OPEN_LOAD_SUMMARY_BIT  = 1;

   // Selector codes.
   localparam logic [3:0] SEL_CH_FIRST = 4'h2;
   localparam logic [3:0] SEL_CH_LAST  = 4'h7;
   localparam logic [3:0] SEL_LOOP     = 4'hA;
   localparam logic [3:0] SEL_IDLE     = 4'hF;
   localparam logic [3:0] SEL_RESET    = 4'h0;

   // Timing in microseconds and derived cycle counts.
   localparam int unsigned T_SET_US  = 50;
   localparam int unsigned T_SW_US   = 10;
   localparam int unsigned T_SYNC_US = 20;
   localparam int unsigned T_ONMX_US = 30;
   localparam int unsigned CYC_SET  = (T_SET_US * (CLK_HZ / 1_000_000) < 1) ? 1 : T_SET_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CYC_SW   = (T_SW_US * (CLK_HZ / 1_000_000) < 1) ? 1 : T_SW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CYC_SYNC = (T_SYNC_US * (CLK_HZ / 1_000_000) < 1) ? 1 : T_SYNC_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CYC_ONMX = (T_ONMX_US * (CLK_HZ / 1_000_000) < 1) ? 1 : T_ONMX_US * (CLK_HZ / 1_000_000);
   localparam logic [11:0] CNT_DIRECT_FIRST = 12'(CYC_SET + CYC_SYNC);
   localparam logic [11:0] CNT_DIRECT_NEXT  = 12'(CYC_SW + CYC_SYNC);
   localparam logic [11:0] CNT_SET          = 12'(CYC_SET);
   localparam logic [11:0] CNT_PWM_ON       = 12'(CYC_ONMX + CYC_SW);

   // Per-channel analog inputs from the output stage.
   typedef struct packed {
      logic [NCH-1:0] ds_below;     // Low-side drain-source below threshold.
      logic [NCH-1:0] out_above;    // Output above threshold.
      logic [NCH-1:0] cur_below;    // Load current below open-load threshold.
      logic [NCH-1:0] high_side;    // Channel used high-side.
      logic [NCH-1:0] auto_cfg;     // Channel is auto-configurable.
      logic [NCH-1:0] fault_ev;     // Over-load or over-temperature event.
   } scd_analog_t;

   // Per-channel drive status.
   typedef struct packed {
      logic [NCH-1:0] on;           // Channel switched on.
      logic [NCH-1:0] pwm;          // Channel driven by a PWM generator.
      logic [NCH-1:0] pwm_gen1;     // Mapped to generator 1 rather than 0.
   } scd_drive_t;

   typedef enum logic [2:0] {LP_IDLE, LP_DIRECT, LP_PWM_WAIT, LP_PWM_ON, LP_DONE} scd_loop_t;
endpackage

// [rtl/scd_top.sv]
// Diagnosis block of an eight-channel power switch: faults, output monitor, on-state open load.
// Assumes a classic Wishbone master and analog comparator results synchronous to clk_i.
// How it works
// RL1: Each channel's diagnosis is computed on its own, apart from parallel pairs.
// RL2: Overload or overtemperature sets the fault flag and latches the channel off.
// RL3: Monitor bit is 1 for low-side below threshold or high-side output above.
// RL4: Monitor bits are refreshed with live comparators on each monitor register read.
// RL5: Software waits the settling time after current enable or channel toggle.
// RL6: Open load seen by the monitor is only reported, never latches off.
// RL7: Software reads the monitor while the channels concerned are off.
// RL8: Off-state summary is OR of monitor bits of off channels with current enabled.
// RL9: On-state open load only on high-side auto channels: low current with high output.
// RL10: After reset on-state open-load detection stays inactive until the selector is written.
// RL11: Selector 2 to 7 tests one channel after the set time; others read default.
// RL12: Software keeps the channel on for the minimum on time before testing.
// RL13: Direct mode refreshes results on every read and mirrors them into the summary.
// RL14: Selector code A starts an autonomous loop over the high-side auto channels among channels 2 to 7.
// RL15: Loop tests direct channels first from channel 2, then PWM channels.
// RL16: PWM channels on generator 0 are tested before generator 1.
// RL17: The first direct result takes set plus sync time, later ones switch plus sync.
// RL18: A direct channel that is off at its test gets result 0.
// RL19: PWM channel test waits for on phase, completes after max-on plus switch time.
// RL20: A PWM on phase shorter than that forces the result to 0.
// RL21: Loop end returns selector to F; results hold until a new loop.
// RL22: Summary is live OR in loop, last result at F, 0 for reserved codes.
// RL23: The latch-clear bit returns to 0 once the latch has been released.
// RL24: Results and summaries read 0 after reset until a diagnosis produced one.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module scd_top
   import scd_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   // Output stage.
   input  wire scd_analog_t ana_i,
   input  wire scd_drive_t  drv_i,
   input  wire logic [3:0]  parallel_i,
   output logic [NCH-1:0]   latch_off_o,
   output logic [NCH-1:0]   iol_en_o,
   output logic [3:0]       mux_sel_o
);
   logic [NCH-1:0] fault_flag;
   logic [NCH-1:0] latch_off;
   logic [NCH-1:0] latch_clr;
   logic [NCH-1:0] clr_wr;
   logic [NCH-1:0] fault_ev;
   logic [NCH-1:0] iol_reg;
   logic [NCH-1:0] on_open_load_summary_reg;
   logic [3:0]     selector_reg;
   logic           on_open_load_summary_sum_reg;
   logic           armed_reg;
   logic [3:0]     cur_ch_reg;
   logic [11:0]    cnt_reg;
   logic           first_reg;
   scd_loop_t      lp_reg;
   logic [NCH-1:0] done_reg;
   logic           gen_phase_reg;
   logic           req;
   logic           rd_std;
   logic           rd_on_open_load_summary;
   logic           wr_sel;
   logic [NCH-1:0] osm_live;
   logic [NCH-1:0] on_open_load_summary_cand;
   logic [NCH-1:0] on_open_load_summary_view;
   logic [NCH-1:0] cand_direct;
   logic [NCH-1:0] cand_pwm;
   logic [3:0]     pick_direct;
   logic [3:0]     pick_pwm;
   logic           have_direct;
   logic           have_pwm;
   logic           on_open_load_summary_now;
   logic [2:0]     ch3;

   assign req     = cyc_i && stb_i && !ack_o && !err_o;
   assign rd_std  = req && !we_i && adr_i == ADR_STD_DIAG;
   assign rd_on_open_load_summary = req && !we_i && adr_i == ADR_ON_OPEN_LOAD_SUMMARY;
   assign wr_sel  = req && we_i && sel_i[0] && adr_i == ADR_SELECTOR;
   assign ch3     = cur_ch_reg[2:0];

   // Paired channels share fault events; otherwise each channel stands alone.
   always_comb begin
      fault_ev = ana_i.fault_ev;
      for (int p = 0; p < 4; p++) begin
         if (parallel_i[p]) begin
            fault_ev[2*p]   = ana_i.fault_ev[2*p] | ana_i.fault_ev[2*p+1]; // see RL1
            fault_ev[2*p+1] = ana_i.fault_ev[2*p] | ana_i.fault_ev[2*p+1];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         assign clr_wr[g] = req && we_i && sel_i[0] && adr_i == ADR_LATCH_CLR && dat_i[g];
         scd_fault_chan u_fault (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .fault_ev_i (fault_ev[g]),
            .clr_wr_i   (clr_wr[g]),
            .fault_o    (fault_flag[g]),
            .latched_o  (latch_off[g]),
            .clr_o      (latch_clr[g])
         );
      end
   endgenerate

   // Live comparator result per channel and on-state open-load candidate.
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         osm_live[i]  = (ana_i.auto_cfg[i] && ana_i.high_side[i]) ? ana_i.out_above[i]
                                                                   : ana_i.ds_below[i]; // see RL3
         on_open_load_summary_cand[i] = ana_i.auto_cfg[i] && ana_i.high_side[i]
                        && ana_i.cur_below[i] && ana_i.out_above[i]; // see RL9
      end
      cand_direct = ana_i.auto_cfg & ana_i.high_side & ~drv_i.pwm & ~done_reg;
      cand_pwm    = ana_i.auto_cfg & ana_i.high_side & drv_i.pwm & ~done_reg
                    & (gen_phase_reg ? drv_i.pwm_gen1 : ~drv_i.pwm_gen1); // see RL16
      pick_direct = 4'h0;
      pick_pwm    = 4'h0;
      have_direct = 1'b0;
      have_pwm    = 1'b0;
      for (int i = NCH - 1; i >= 2; i--) begin
         if (cand_direct[i]) begin
            pick_direct = 4'(i); // see RL15
            have_direct = 1'b1;
         end
         if (cand_pwm[i]) begin
            pick_pwm = 4'(i);
            have_pwm = 1'b1;
         end
      end
   end

   // Direct mode shows only the selected channel, and only once the set time has run out.
   always_comb begin
      on_open_load_summary_view = on_open_load_summary_reg;
      if (armed_reg && selector_reg >= SEL_CH_FIRST && selector_reg <= SEL_CH_LAST) begin
         on_open_load_summary_view      = '0; // see RL11
         on_open_load_summary_view[ch3] = (cnt_reg == 12'h000) && on_open_load_summary_cand[ch3];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         iol_reg <= '0;
      end else if (req && we_i && sel_i[0] && adr_i == ADR_IOL) begin
         iol_reg <= dat_i[NCH-1:0];
      end
   end

   // Selector, armed after first write, and loop sequencer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         selector_reg  <= SEL_RESET;
         armed_reg     <= 1'b0; // see RL10
         lp_reg        <= LP_IDLE;
         cur_ch_reg    <= 4'h0;
         cnt_reg       <= 12'h000;
         first_reg     <= 1'b1;
         done_reg      <= '0;
         gen_phase_reg <= 1'b0;
      end else if (wr_sel) begin
         selector_reg  <= dat_i[3:0];
         armed_reg     <= 1'b1;
         first_reg     <= 1'b1;
         done_reg      <= '0;
         gen_phase_reg <= 1'b0;
         cur_ch_reg    <= dat_i[3:0];
         cnt_reg       <= (dat_i[3:0] == SEL_LOOP) ? 12'h000 : CNT_SET; // see RL17
         lp_reg        <= (dat_i[3:0] == SEL_LOOP) ? LP_DIRECT : LP_IDLE; // see RL14
      end else if (selector_reg >= SEL_CH_FIRST && selector_reg <= SEL_CH_LAST) begin
         if (cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001; // see RL11
         end
      end else begin
         unique case (lp_reg)
            LP_IDLE, LP_DONE: begin
               lp_reg <= lp_reg;
            end
            LP_DIRECT: begin
               if (cnt_reg != 12'h000) begin
                  cnt_reg <= cnt_reg - 12'h001;
               end else if (have_direct) begin
                  cur_ch_reg <= pick_direct;
                  done_reg[pick_direct[2:0]] <= 1'b1;
                  cnt_reg    <= first_reg ? CNT_DIRECT_FIRST : CNT_DIRECT_NEXT; // see RL17
                  first_reg  <= 1'b0;
               end else begin
                  lp_reg  <= LP_PWM_WAIT;
                  cnt_reg <= CNT_SET;
               end
            end
            LP_PWM_WAIT: begin
               if (cnt_reg != 12'h000) begin
                  cnt_reg <= cnt_reg - 12'h001;
               end else if (have_pwm) begin
                  cur_ch_reg <= pick_pwm;
                  if (drv_i.on[pick_pwm[2:0]]) begin
                     lp_reg  <= LP_PWM_ON; // see RL19
                     cnt_reg <= CNT_PWM_ON;
                  end
               end else if (!gen_phase_reg) begin
                  gen_phase_reg <= 1'b1;
               end else begin
                  lp_reg       <= LP_DONE;
                  selector_reg <= SEL_IDLE; // see RL21
               end
            end
            LP_PWM_ON: begin
               if (!drv_i.on[ch3] || cnt_reg == 12'h001) begin
                  done_reg[ch3] <= 1'b1;
                  lp_reg        <= LP_PWM_WAIT;
                  cnt_reg       <= CNT_SET;
               end else begin
                  cnt_reg <= cnt_reg - 12'h001;
               end
            end
            default: begin
               lp_reg <= LP_IDLE;
            end
         endcase
      end
   end

   // Result bits: direct mode refreshes on read, loop writes the tested channel.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_open_load_summary_reg <= '0; // see RL24
      end else if (wr_sel && dat_i[3:0] == SEL_LOOP) begin
         on_open_load_summary_reg <= '0;
      end else if (armed_reg && selector_reg >= SEL_CH_FIRST && selector_reg <= SEL_CH_LAST) begin
         if (rd_on_open_load_summary || rd_std) begin
            on_open_load_summary_reg <= on_open_load_summary_view; // see RL13
         end
      end else if (lp_reg == LP_DIRECT && cnt_reg == 12'h001 && !first_reg) begin
         on_open_load_summary_reg[ch3] <= drv_i.on[ch3] && on_open_load_summary_cand[ch3]; // see RL18
      end else if (lp_reg == LP_PWM_ON) begin
         if (!drv_i.on[ch3]) begin
            on_open_load_summary_reg[ch3] <= 1'b0; // see RL20
         end else if (cnt_reg == 12'h001) begin
            on_open_load_summary_reg[ch3] <= on_open_load_summary_cand[ch3];
         end
      end
   end

   // On-state summary per selector code.
   always_comb begin
      unique case (1'b1)
         selector_reg >= SEL_CH_FIRST && selector_reg <= SEL_CH_LAST: on_open_load_summary_now = on_open_load_summary_view[ch3]; // see RL13
         selector_reg == SEL_LOOP || selector_reg == SEL_IDLE:        on_open_load_summary_now = |on_open_load_summary_reg; // see RL22
         default:                                                     on_open_load_summary_now = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_open_load_summary_sum_reg <= 1'b0;
      end else begin
         on_open_load_summary_sum_reg <= armed_reg && on_open_load_summary_now; // see RL22
      end
   end

   // Wishbone read mux and single-cycle acknowledge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         if (req) begin
            ack_o <= 1'b1;
            unique case (adr_i)
               ADR_FAULT:     dat_o[NCH-1:0] <= fault_flag;
               ADR_LATCH_CLR: dat_o[NCH-1:0] <= latch_clr;
               ADR_OSM:       dat_o[NCH-1:0] <= osm_live; // see RL4 RL6
               ADR_IOL:       dat_o[NCH-1:0] <= iol_reg;
               ADR_SELECTOR:  dat_o[3:0]     <= selector_reg;
               ADR_ON_OPEN_LOAD_SUMMARY:      dat_o[NCH-1:0] <= on_open_load_summary_view;
               ADR_STD_DIAG: begin
                  dat_o[STD_OFF_OPEN_LOAD_SUMMARY_BIT] <= |(osm_live & ~drv_i.on & iol_reg); // see RL8
                  dat_o[STD_ON_OPEN_LOAD_SUMMARY_BIT]  <= on_open_load_summary_sum_reg;
               end
               ADR_CFG:       dat_o[NCH-1:0] <= latch_off;
               default: begin
                  ack_o <= 1'b0;
                  err_o <= 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_off_o <= '0;
         iol_en_o    <= '0;
         mux_sel_o   <= 4'h0;
      end else begin
         latch_off_o <= latch_off; // see RL2
         iol_en_o    <= iol_reg;
         mux_sel_o   <= cur_ch_reg;
      end
   end

   AST_OSM_NO_LATCH: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
      !(|fault_ev) && !(|latch_off) |=> !(|latch_off))
      else $error("Latch set without a fault event.");
   AST_ON_OPEN_LOAD_SUMMARY_RESET_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
      !armed_reg |-> !on_open_load_summary_sum_reg && on_open_load_summary_reg == '0)
      else $error("On-state result before selector written.");
   AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // see RL22
      armed_reg && $stable(selector_reg) && selector_reg inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE}
      |=> !on_open_load_summary_sum_reg)
      else $error("Summary not zero on reserved selector.");
   AST_LOOP_START: assert property (@(posedge clk_i) disable iff (rst_i) // see RL14
      wr_sel && dat_i[3:0] == SEL_LOOP |=> lp_reg == LP_DIRECT && on_open_load_summary_reg == '0)
      else $error("Loop did not start.");
   AST_LOOP_END: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
      $rose(lp_reg == LP_DONE) |-> selector_reg == SEL_IDLE)
      else $error("Selector not restored at loop end.");
   AST_DIRECT_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // see RL18
      lp_reg == LP_DIRECT && cnt_reg == 12'h001 && !first_reg && !drv_i.on[ch3] && !wr_sel
      |=> !on_open_load_summary_reg[$past(ch3)])
      else $error("Off direct channel kept a result.");
   AST_PWM_SHORT: assert property (@(posedge clk_i) disable iff (rst_i) // see RL20
      lp_reg == LP_PWM_ON && !drv_i.on[ch3] && !wr_sel |=> !on_open_load_summary_reg[$past(ch3)] && lp_reg == LP_PWM_WAIT)
      else $error("Short PWM phase kept a result.");
   AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
      req |=> (ack_o ^ err_o) ##1 !ack_o)
      else $error("Bus answer not single-cycle.");
endmodule

// [verif/scd_stage_model.sv]
// Behavioural output stage that feeds comparator levels and channel drive to the diagnosis block.
// Assumes the bench sets the wanted drive and the levels; the latch state comes from the block.
`timescale 1ns/1ns
module scd_stage_model
   import scd_pkg::*;
(
   // Clock.
   input  wire logic           clk_i,
   // Bench settings.
   input  wire logic [NCH-1:0] want_on_i,
   input  wire scd_analog_t    cfg_i,
   input  wire logic [NCH-1:0] pwm_i,
   input  wire logic [NCH-1:0] gen1_i,
   // Block side.
   input  wire logic [NCH-1:0] latch_off_i,
   output scd_analog_t         ana_o,
   output scd_drive_t          drv_o
);
   // A latched channel stays off until the block releases its latch.
   always_ff @(posedge clk_i) begin
      drv_o.on       <= want_on_i & ~latch_off_i;
      drv_o.pwm      <= pwm_i;
      drv_o.pwm_gen1 <= gen1_i;
   end
   assign ana_o = cfg_i;
endmodule

// [verif/testbench.sv]
// Self-checking bench: Wishbone register accesses with expected values.
// Assumes the stage model drives the comparator and drive inputs.
`timescale 1ns/1ns
module testbench
   import scd_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic        ack;
   logic        err;
   logic        e;
   logic [3:0]  sel;
   logic [3:0]  mux_sel;
   logic [7:0]  adr;
   logic [7:0]  want_on;
   logic [7:0]  pwm;
   logic [7:0]  gen1;
   logic [7:0]  latch_off;
   logic [7:0]  iol_en;
   logic [31:0] dat_w;
   logic [31:0] dat_r;
   logic [31:0] q;
   scd_analog_t cfg;
   scd_analog_t ana;
   scd_drive_t  drv;
   int          error_cnt;
   int          n_compared;
   int          cyc_cnt;

   always #50 clk = ~clk;

   scd_top i_scd_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .err_o(err), .ana_i(ana), .drv_i(drv),
      .parallel_i(4'h0), .latch_off_o(latch_off), .iol_en_o(iol_en), .mux_sel_o(mux_sel));
   scd_stage_model i_scd_stage_model (.clk_i(clk), .want_on_i(want_on), .cfg_i(cfg), .pwm_i(pwm), .gen1_i(gen1),
      .latch_off_i(latch_off), .ana_o(ana), .drv_o(drv));

   task automatic give_verdict();
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Classic single cycle; holds the request until ack or err is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      @(posedge clk);
      while (ack !== 1'b1 && err !== 1'b1) begin
         @(posedge clk);
      end
      q = dat_r;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      cmp($sformatf("register %h", a), exp, q);
   endtask

   // Polls the selector until the loop hands it back, then checks the idle code.
   task automatic await_idle();
      q = 32'h0;
      for (int i = 0; i < 40 && q[3:0] !== SEL_IDLE; i++) begin
         repeat (100) @(posedge clk);
         wb(1'b0, ADR_SELECTOR, 32'h0);
      end
      cmp("selector", {28'h0, SEL_IDLE}, q);
   endtask

   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'hF;
      adr = 8'h00;
      dat_w = 32'h0;
      want_on = 8'h00;
      pwm = 8'h00;
      gen1 = 8'h00;
      cfg = '{ds_below: 8'h01, out_above: 8'h14, cur_below: 8'h66, high_side: 8'hFC,
              auto_cfg: 8'hFC, fault_ev: 8'h00};
      error_cnt = 0;
      n_compared = 0;
      cyc_cnt = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h0);
      rd(ADR_STD_DIAG, 32'h0);
      rd(ADR_SELECTOR, 32'h0);
      wb(1'b0, 8'h20, 32'h0);
      cmp("unmapped error", 32'h1, {31'h0, e});
      wb(1'b1, ADR_IOL, 32'h4);
      repeat (20) @(posedge clk);
      cmp("iol_en_o", 32'h4, {24'h0, iol_en});
      rd(ADR_OSM, 32'h15);
      rd(ADR_STD_DIAG, 32'h1);
      wb(1'b1, ADR_IOL, 32'h2);
      rd(ADR_STD_DIAG, 32'h0);
      rd(ADR_CFG, 32'h0);
      @(posedge clk);
      cfg.out_above <= 8'h00;
      rd(ADR_OSM, 32'h01);
      @(posedge clk);
      cfg.fault_ev <= 8'h08;
      @(posedge clk);
      cfg.fault_ev <= 8'h00;
      rd(ADR_FAULT, 32'h08);
      rd(ADR_CFG, 32'h08);
      cmp("latch_off_o", 32'h08, {24'h0, latch_off});
      wb(1'b1, ADR_LATCH_CLR, 32'h08);
      repeat (5) @(posedge clk);
      rd(ADR_CFG, 32'h0);
      rd(ADR_LATCH_CLR, 32'h0);
      want_on <= 8'hFF;
      cfg.out_above <= 8'hFC;
      repeat (20) @(posedge clk);
      wb(1'b1, ADR_SELECTOR, {28'h0, SEL_CH_FIRST});
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h0);
      cmp("mux_sel_o", 32'h2, {28'h0, mux_sel});
      repeat (CNT_SET + 20) @(posedge clk);
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h04);
      rd(ADR_STD_DIAG, 32'h02);
      wb(1'b1, ADR_SELECTOR, 32'hB);
      rd(ADR_STD_DIAG, 32'h0);
      want_on <= 8'hDF;
      repeat (20) @(posedge clk);
      wb(1'b1, ADR_SELECTOR, {28'h0, SEL_LOOP});
      repeat (CNT_DIRECT_FIRST - 20) @(posedge clk);
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h0);
      repeat (40) @(posedge clk);
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h04);
      rd(ADR_STD_DIAG, 32'h02);
      await_idle();
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h44);
      repeat (200) @(posedge clk);
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h44);
      rd(ADR_STD_DIAG, 32'h02);
      pwm <= 8'h60;
      gen1 <= 8'h20;
      want_on <= 8'h5F;
      repeat (20) @(posedge clk);
      wb(1'b1, ADR_SELECTOR, {28'h0, SEL_LOOP});
      repeat (3500) @(posedge clk);
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h44);
      rd(ADR_SELECTOR, {28'h0, SEL_LOOP});
      cmp("mux_sel_o", 32'h5, {28'h0, mux_sel});
      want_on <= 8'h7F;
      repeat (100) @(posedge clk);
      want_on <= 8'h5F;
      await_idle();
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h44);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(ADR_ON_OPEN_LOAD_SUMMARY, 32'h0);
      rd(ADR_STD_DIAG, 32'h0);
      rd(ADR_SELECTOR, 32'h0);
      give_verdict();
   end
endmodule
